/* inc/psq_regs.svh */
// register offsets, field positions, reset values and timing counts of the purge sequencer
// Operation
// - only a low-to-high edge on the selected input starts a purge
// - host purge command honoured only in ready mode; ignored when sent in scan mode
// - trigger edge starts a purge from ready mode or scan mode
// - a configuration setting selects which input acts as purge trigger
// - a purge first drives the pre/post pattern onto the outputs
// - pre/post hold is 0 to 5 seconds, default 1, zero skips the wait
// - after the pre phase the purge pattern drives the outputs
// - main phase ends on purge hold expiry or stop; hold 0 to 3600, default 10
// - purge hold of zero runs the main phase until a stop command
// - after the main phase the pre/post pattern is driven for the pre/post hold
// - a command-started purge returns to ready mode after the post phase
// - scanning is suspended for the whole purge sequence
// - a trigger-started purge restores the mode held when the edge arrived
// - reset sets pre/post pattern to zero and purge pattern to E0
// - four selectable trigger inputs and five general digital outputs driven by the patterns
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH

`define PSQ_ADDR_W         8
`define PSQ_DATA_W         32
`define PSQ_OFS_CMD        8'h00
`define PSQ_OFS_PRE_PAT    8'h04
`define PSQ_OFS_PG_PAT     8'h08
`define PSQ_OFS_PRE_HOLD   8'h0C
`define PSQ_OFS_PG_HOLD    8'h10
`define PSQ_OFS_IN_SEL     8'h14
`define PSQ_OFS_IDLE_PAT   8'h18
`define PSQ_OFS_STATUS     8'h1C

`define PSQ_CMD_PURGE      0
`define PSQ_CMD_STOP       1
`define PSQ_CMD_SCAN       2
`define PSQ_CMD_READY      3

`define PSQ_PAT_W          8
`define PSQ_GEN_W          5
`define PSQ_DIN_W          4
`define PSQ_SEL_W          2
`define PSQ_PRE_HOLD_W     3
`define PSQ_PG_HOLD_W      12
`define PSQ_PRESC_W        27

`define PSQ_RST_PRE_PAT    8'h00
`define PSQ_RST_PG_PAT     8'hE0
`define PSQ_RST_IDLE_PAT   8'h00
`define PSQ_RST_PRE_HOLD   3'h1
`define PSQ_RST_PG_HOLD    12'h00A
`define PSQ_RST_IN_SEL     2'h0
`define PSQ_MAX_PRE_HOLD   3'h5
`define PSQ_MAX_PG_HOLD    12'hE10

`define PSQ_CLK_PERIOD_NS  10
`define PSQ_TICK_NS        1000000000
`define PSQ_TICK_CYCLES    (`PSQ_TICK_NS / `PSQ_CLK_PERIOD_NS)

`endif

/* inc/psq_pkg.sv */
// types of the purge sequencer: states, bus request and the module state record
package psq_pkg;
	`include "psq_regs.svh"

	typedef enum logic [3:0] {
		PSQ_IDLE = 4'b0001,
		PSQ_PRE  = 4'b0010,
		PSQ_MAIN = 4'b0100,
		PSQ_POST = 4'b1000
	} psq_fsm_e;

	typedef struct packed {
		logic [`PSQ_ADDR_W-1:0] addr;
		logic [`PSQ_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} psq_bus_s;

	typedef struct packed {
		psq_fsm_e                   fsm;
		logic                       scan_mode;
		logic                       from_trig;
		logic [`PSQ_PAT_W-1:0]      pre_pat;
		logic [`PSQ_PAT_W-1:0]      pg_pat;
		logic [`PSQ_PAT_W-1:0]      idle_pat;
		logic [`PSQ_PRE_HOLD_W-1:0] pre_hold;
		logic [`PSQ_PG_HOLD_W-1:0]  pg_hold;
		logic [`PSQ_SEL_W-1:0]      in_sel;
		logic [`PSQ_DIN_W-1:0]      sync1;
		logic [`PSQ_DIN_W-1:0]      sync2;
		logic                       trig_prev;
		logic [`PSQ_PRESC_W-1:0]    presc;
		logic [`PSQ_PG_HOLD_W-1:0]  secs;
		logic [`PSQ_PAT_W-1:0]      dout;
		logic                       scan_run;
		logic [`PSQ_DATA_W-1:0]     rdata;
	} psq_state_s;
endpackage : psq_pkg

/* rtl/psq_top.sv */
// purge sequencer: trigger edge detect, phase timer, output patterns and register port
`timescale 1ns/1ps
`include "psq_regs.svh"
module psq_top #(
	parameter int TICK_CYCLES = `PSQ_TICK_CYCLES
) (
	input  wire logic                   mclk_in,
	input  wire logic                   resetn_in,
	input  wire psq_pkg::psq_bus_s      bus_in,
	input  wire logic [`PSQ_DIN_W-1:0]  din_in,
	output logic [`PSQ_DATA_W-1:0]      rdata_out,
	output logic [`PSQ_GEN_W-1:0]       gen_out,
	output logic [2:0]                  valve_out,
	output logic                        scan_run_out
);
	import psq_pkg::*;

	localparam logic [`PSQ_PRESC_W-1:0] TICK_LAST = `PSQ_PRESC_W'(TICK_CYCLES - 1);

	localparam psq_state_s ST_RST = '{
		fsm:       PSQ_IDLE,
		scan_mode: 1'b0,
		from_trig: 1'b0,
		pre_pat:   `PSQ_RST_PRE_PAT,
		pg_pat:    `PSQ_RST_PG_PAT,
		idle_pat:  `PSQ_RST_IDLE_PAT,
		pre_hold:  `PSQ_RST_PRE_HOLD,
		pg_hold:   `PSQ_RST_PG_HOLD,
		in_sel:    `PSQ_RST_IN_SEL,
		// synchroniser starts high so a pin already high at reset gives no edge
		sync1:     '1,
		sync2:     '1,
		trig_prev: 1'b1,
		presc:     '0,
		secs:      '0,
		dout:      `PSQ_RST_IDLE_PAT,
		scan_run:  1'b0,
		rdata:     '0
	};

	psq_state_s st_reg;
	psq_state_s st_next;

	logic trig_lvl;
	logic trig_edge;
	logic cmd_wr;
	logic cmd_purge;
	logic cmd_stop;
	logic tick;
	logic restart;
	logic [`PSQ_DATA_W-1:0] rd_mux;

	always_comb begin
		st_next = st_reg;
		restart = 1'b0;

		// two-stage synchroniser on the external inputs
		st_next.sync1 = din_in;
		st_next.sync2 = st_reg.sync1;
		trig_lvl = st_reg.sync2[st_reg.in_sel];
		trig_edge = trig_lvl & ~st_reg.trig_prev;
		st_next.trig_prev = trig_lvl;

		cmd_wr = bus_in.wr && (bus_in.addr == `PSQ_OFS_CMD);
		cmd_purge = cmd_wr && bus_in.wdata[`PSQ_CMD_PURGE];
		cmd_stop = cmd_wr && bus_in.wdata[`PSQ_CMD_STOP];

		// configuration writes, hold values clamped to their ranges
		if (bus_in.wr) begin
			case (bus_in.addr)
				`PSQ_OFS_PRE_PAT:  st_next.pre_pat = bus_in.wdata[`PSQ_PAT_W-1:0];
				`PSQ_OFS_PG_PAT:   st_next.pg_pat = bus_in.wdata[`PSQ_PAT_W-1:0];
				`PSQ_OFS_IDLE_PAT: st_next.idle_pat = bus_in.wdata[`PSQ_PAT_W-1:0];
				`PSQ_OFS_IN_SEL:   st_next.in_sel = bus_in.wdata[`PSQ_SEL_W-1:0];
				`PSQ_OFS_PRE_HOLD: begin
					if (bus_in.wdata > `PSQ_DATA_W'(`PSQ_MAX_PRE_HOLD))
						st_next.pre_hold = `PSQ_MAX_PRE_HOLD;
					else
						st_next.pre_hold = bus_in.wdata[`PSQ_PRE_HOLD_W-1:0];
				end
				`PSQ_OFS_PG_HOLD: begin
					if (bus_in.wdata > `PSQ_DATA_W'(`PSQ_MAX_PG_HOLD))
						st_next.pg_hold = `PSQ_MAX_PG_HOLD;
					else
						st_next.pg_hold = bus_in.wdata[`PSQ_PG_HOLD_W-1:0];
				end
				default: ;
			endcase
		end

		// one-second tick and whole-second counter
		tick = (st_reg.presc == TICK_LAST);
		if (tick) begin
			st_next.presc = '0;
			st_next.secs = st_reg.secs + `PSQ_PG_HOLD_W'(1);
		end else begin
			st_next.presc = st_reg.presc + `PSQ_PRESC_W'(1);
		end

		case (st_reg.fsm)
			PSQ_IDLE: begin
				if (trig_edge) begin
					st_next.fsm = PSQ_PRE;
					st_next.from_trig = 1'b1;
					restart = 1'b1;
				end else if (cmd_purge && !st_reg.scan_mode) begin
					st_next.fsm = PSQ_PRE;
					st_next.from_trig = 1'b0;
					restart = 1'b1;
				end else if (cmd_wr) begin
					// mode changes only between sequences, so the held mode is restored
					if (bus_in.wdata[`PSQ_CMD_SCAN])
						st_next.scan_mode = 1'b1;
					else if (bus_in.wdata[`PSQ_CMD_READY])
						st_next.scan_mode = 1'b0;
				end
			end
			PSQ_PRE: begin
				if (st_reg.secs >= `PSQ_PG_HOLD_W'(st_reg.pre_hold)) begin
					st_next.fsm = PSQ_MAIN;
					restart = 1'b1;
				end
			end
			PSQ_MAIN: begin
				if (cmd_stop || (st_reg.pg_hold != '0 && st_reg.secs >= st_reg.pg_hold)) begin
					st_next.fsm = PSQ_POST;
					restart = 1'b1;
				end
			end
			PSQ_POST: begin
				if (st_reg.secs >= `PSQ_PG_HOLD_W'(st_reg.pre_hold))
					st_next.fsm = PSQ_IDLE;
			end
			default: st_next.fsm = PSQ_IDLE;
		endcase

		if (restart) begin
			st_next.presc = '0;
			st_next.secs = '0;
		end

		// output pattern follows the phase being entered
		case (st_next.fsm)
			PSQ_PRE:  st_next.dout = st_next.pre_pat;
			PSQ_MAIN: st_next.dout = st_next.pg_pat;
			PSQ_POST: st_next.dout = st_next.pre_pat;
			default:  st_next.dout = st_next.idle_pat;
		endcase
		st_next.scan_run = st_next.scan_mode && (st_next.fsm == PSQ_IDLE);

		case (bus_in.addr)
			`PSQ_OFS_PRE_PAT:  rd_mux = `PSQ_DATA_W'(st_reg.pre_pat);
			`PSQ_OFS_PG_PAT:   rd_mux = `PSQ_DATA_W'(st_reg.pg_pat);
			`PSQ_OFS_IDLE_PAT: rd_mux = `PSQ_DATA_W'(st_reg.idle_pat);
			`PSQ_OFS_PRE_HOLD: rd_mux = `PSQ_DATA_W'(st_reg.pre_hold);
			`PSQ_OFS_PG_HOLD:  rd_mux = `PSQ_DATA_W'(st_reg.pg_hold);
			`PSQ_OFS_IN_SEL:   rd_mux = `PSQ_DATA_W'(st_reg.in_sel);
			`PSQ_OFS_STATUS:   rd_mux = `PSQ_DATA_W'({st_reg.secs, st_reg.scan_run, st_reg.from_trig,
						st_reg.scan_mode, st_reg.fsm});
			default:           rd_mux = '0;
		endcase
		st_next.rdata = bus_in.rd ? rd_mux : '0;
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in)
			st_reg <= ST_RST;
		else
			st_reg <= st_next;
	end

	assign rdata_out = st_reg.rdata;
	assign gen_out = st_reg.dout[`PSQ_GEN_W-1:0];
	assign valve_out = st_reg.dout[`PSQ_PAT_W-1:`PSQ_GEN_W];
	assign scan_run_out = st_reg.scan_run;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);

	chk_level_no_start: assert property (
		(st_reg.fsm == PSQ_IDLE && !trig_edge && !cmd_purge) |=> st_reg.fsm == PSQ_IDLE
	) else $error("purge started without an edge or command");

	chk_cmd_scan_refused: assert property (
		(st_reg.fsm == PSQ_IDLE && st_reg.scan_mode && cmd_purge && !trig_edge) |=> st_reg.fsm == PSQ_IDLE
	) else $error("purge command honoured outside ready mode");

	chk_trig_starts: assert property (
		(st_reg.fsm == PSQ_IDLE && trig_edge) |=> (st_reg.fsm == PSQ_PRE && st_reg.from_trig)
	) else $error("trigger edge did not start a purge");

	chk_pre_pattern: assert property (
		(st_reg.fsm == PSQ_PRE || st_reg.fsm == PSQ_POST) |-> st_reg.dout == st_reg.pre_pat
	) else $error("pre/post pattern not driven");

	chk_pre_zero_skip: assert property (
		(st_reg.fsm == PSQ_PRE && st_reg.pre_hold == '0) |=> st_reg.fsm == PSQ_MAIN
	) else $error("zero pre/post hold did not skip");

	chk_main_pattern: assert property (
		st_reg.fsm == PSQ_MAIN |-> st_reg.dout == st_reg.pg_pat
	) else $error("purge pattern not driven in main phase");

	chk_stop_ends: assert property (
		(st_reg.fsm == PSQ_MAIN && cmd_stop) |=> (st_reg.fsm == PSQ_POST && st_reg.secs == '0)
	) else $error("stop did not end the main phase");

	chk_hold_zero_stays: assert property (
		(st_reg.fsm == PSQ_MAIN && st_reg.pg_hold == '0 && !cmd_stop) |=> st_reg.fsm == PSQ_MAIN
	) else $error("infinite purge ended without stop");

	chk_main_to_post: assert property (
		$fell(st_reg.fsm == PSQ_MAIN) |-> st_reg.fsm == PSQ_POST
	) else $error("main phase not followed by post phase");

	chk_mode_kept: assert property (
		st_reg.fsm != PSQ_IDLE |=> st_reg.scan_mode == $past(st_reg.scan_mode)
	) else $error("mode changed during purge");

	chk_scan_held: assert property (
		st_reg.fsm != PSQ_IDLE |-> !scan_run_out
	) else $error("scan running during purge");

	chk_reset_values: assert property (
		$past(resetn_in) == 1'b0 |-> (st_reg.pre_pat == 8'h00 && st_reg.pg_pat == 8'hE0)
	) else $error("pattern reset values wrong");

	chk_busy_ignore: assert property (
		((st_reg.fsm == PSQ_MAIN || st_reg.fsm == PSQ_POST) && (trig_edge || cmd_purge))
		|=> st_reg.fsm != PSQ_PRE
	) else $error("new purge accepted while busy");

	chk_post_to_idle: assert property (
		(st_reg.fsm == PSQ_POST && st_reg.secs >= `PSQ_PG_HOLD_W'(st_reg.pre_hold) && !st_reg.from_trig)
		|=> (st_reg.fsm == PSQ_IDLE && !st_reg.scan_mode)
	) else $error("command purge did not return to ready mode");

	// start and refusal checks
	chk_busy_origin: assert property (
		(st_reg.fsm != PSQ_IDLE && (trig_edge || cmd_purge))
		|=> st_reg.from_trig == $past(st_reg.from_trig)
	) else $error("purge origin changed while busy");

	chk_cmd_starts: assert property (
		(st_reg.fsm == PSQ_IDLE && cmd_purge && !st_reg.scan_mode && !trig_edge)
		|=> (st_reg.fsm == PSQ_PRE && !st_reg.from_trig)
	) else $error("ready-mode purge command not started");

	chk_ready_cmd: assert property (
		(st_reg.fsm == PSQ_IDLE && cmd_wr && !trig_edge && !cmd_purge && !bus_in.wdata[`PSQ_CMD_SCAN])
		|=> (bus_in.wdata[`PSQ_CMD_READY] ? !st_reg.scan_mode : 1'b1)
	) else $error("ready command did not leave scan mode");

	chk_trig_suspends: assert property (
		(st_reg.fsm == PSQ_IDLE && trig_edge && st_reg.scan_mode)
		|=> (st_reg.fsm == PSQ_PRE && st_reg.scan_mode && !scan_run_out)
	) else $error("scan not suspended by trigger purge");

	chk_level_held: assert property (
		(st_reg.fsm == PSQ_IDLE && trig_lvl && st_reg.trig_prev && !cmd_purge)
		|=> st_reg.fsm == PSQ_IDLE
	) else $error("steady trigger level started a purge");

	chk_sync_chain: assert property (
		trig_edge |-> (st_reg.sync2[st_reg.in_sel] && st_reg.sync2 == $past(st_reg.sync1))
	) else $error("trigger edge not from the selected synchronised input");

	// phase timing checks
	chk_pre_entry: assert property (
		$rose(st_reg.fsm == PSQ_PRE)
		|-> (st_reg.dout == st_reg.pre_pat && st_reg.secs == '0 && st_reg.presc == '0)
	) else $error("pre phase entered without pattern or cleared timer");

	chk_pre_wait: assert property (
		(st_reg.fsm == PSQ_PRE && st_reg.secs < `PSQ_PG_HOLD_W'(st_reg.pre_hold))
		|=> st_reg.fsm == PSQ_PRE
	) else $error("pre phase left before its hold expired");

	chk_pre_clamp: assert property (
		st_reg.pre_hold <= `PSQ_MAX_PRE_HOLD
	) else $error("pre/post hold above its range");

	chk_pg_clamp: assert property (
		st_reg.pg_hold <= `PSQ_MAX_PG_HOLD
	) else $error("purge hold above its range");

	chk_pre_to_main: assert property (
		(st_reg.fsm == PSQ_PRE && st_reg.secs >= `PSQ_PG_HOLD_W'(st_reg.pre_hold))
		|=> (st_reg.fsm == PSQ_MAIN && st_reg.dout == st_reg.pg_pat && st_reg.secs == '0)
	) else $error("pre phase did not hand over to the purge pattern");

	chk_main_timeout: assert property (
		(st_reg.fsm == PSQ_MAIN && st_reg.pg_hold != '0 && st_reg.secs >= st_reg.pg_hold)
		|=> st_reg.fsm == PSQ_POST
	) else $error("main phase outlived its hold");

	chk_main_wait: assert property (
		(st_reg.fsm == PSQ_MAIN && !cmd_stop && st_reg.secs < st_reg.pg_hold)
		|=> st_reg.fsm == PSQ_MAIN
	) else $error("main phase ended early");

	chk_post_entry: assert property (
		$rose(st_reg.fsm == PSQ_POST)
		|-> (st_reg.dout == st_reg.pre_pat && st_reg.secs == '0 && st_reg.presc == '0)
	) else $error("post phase entered without pattern or cleared timer");

	chk_post_wait: assert property (
		(st_reg.fsm == PSQ_POST && st_reg.secs < `PSQ_PG_HOLD_W'(st_reg.pre_hold))
		|=> st_reg.fsm == PSQ_POST
	) else $error("post phase left before its hold expired");

	chk_trig_restore: assert property (
		(st_reg.fsm == PSQ_POST && st_reg.secs >= `PSQ_PG_HOLD_W'(st_reg.pre_hold) && st_reg.from_trig)
		|=> (st_reg.fsm == PSQ_IDLE && st_reg.scan_mode == $past(st_reg.scan_mode))
	) else $error("trigger purge did not restore the mode");

	// mode, output and timer checks
	chk_idle_scan: assert property (
		st_reg.fsm == PSQ_IDLE |-> scan_run_out == st_reg.scan_mode
	) else $error("scan not resumed in idle");

	chk_idle_pattern: assert property (
		st_reg.fsm == PSQ_IDLE |-> st_reg.dout == st_reg.idle_pat
	) else $error("idle pattern not driven");

	chk_output_map: assert property (
		{valve_out, gen_out} == st_reg.dout
	) else $error("outputs do not show the active pattern");

	chk_tick_count: assert property (
		(tick && !restart)
		|=> (st_reg.presc == '0 && st_reg.secs == $past(st_reg.secs) + `PSQ_PG_HOLD_W'(1))
	) else $error("second counter did not advance on the tick");

	chk_secs_steady: assert property (
		(!tick && !restart) |=> $stable(st_reg.secs)
	) else $error("second counter moved without a tick");

	chk_read_pulse: assert property (
		!$past(bus_in.rd) |-> rdata_out == '0
	) else $error("read data outside the cycle after a read");

endmodule : psq_top

/* verif/psq_trig_model.sv */
// host-side trigger source: drives the selected purge input and scrambles the others
`timescale 1ns/1ps
module psq_trig_model (
	input  wire logic       mclk_in,
	input  wire logic [1:0] sel_in,
	input  wire logic       level_in,
	input  wire logic       noise_in,
	output logic [3:0]      din_out
);
	logic [3:0] noise_reg = 4'h0;
	// unselected inputs toggle every cycle, so a stray edge there must not start a purge
	always_ff @(posedge mclk_in) begin
		noise_reg <= noise_in ? ~noise_reg : 4'h0;
	end
	always_comb begin
		din_out = noise_reg;
		din_out[sel_in] = level_in;
	end
endmodule : psq_trig_model

/* verif/psq_top_tb_top.sv */
// self-checking bench of the purge sequencer
`timescale 1ns/1ps
module psq_top_tb_top;
	import psq_pkg::*;
	logic        mclk_in = 1'b0;
	logic        resetn_in = 1'b0;
	psq_bus_s    bus = '0;
	logic [1:0]  sel = 2'h0;
	logic [1:0]  s;
	logic        trig = 1'b0;
	logic        noise = 1'b0;
	logic [3:0]  din;
	logic [31:0] rdata;
	logic [31:0] r;
	logic [4:0]  gen;
	logic [2:0]  valve;
	logic        scan_run;
	logic [7:0]  pp, pg, ip;
	int          miscompares = 0;
	int          compares = 0;
	always #5 mclk_in = ~mclk_in;
	psq_top #(.TICK_CYCLES(10)) dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .bus_in(bus), .din_in(din),
		.rdata_out(rdata), .gen_out(gen), .valve_out(valve), .scan_run_out(scan_run));
	psq_trig_model host (.mclk_in(mclk_in), .sel_in(sel), .level_in(trig), .noise_in(noise), .din_out(din));
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_in);
		bus <= '0;
	endtask : wr
	// data are sampled at the edge that closes the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge mclk_in);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_in);
		bus <= '0;
		@(posedge mclk_in);
		r = rdata;
	endtask : rd
	task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t value %h expected %h", $time, g, e);
		end
	endtask : cmp_reg
	task automatic cmp_out(input logic [7:0] e);
		compares++;
		if ({valve, gen} !== e) begin
			miscompares++;
			$display("[ERR] %0t outputs %h expected %h", $time, {valve, gen}, e);
		end
	endtask : cmp_out
	// walk one purge with pre/post hold 1 and purge hold 2; lat covers input synchronising
	task automatic seq(input int lat, input logic sc);
		cyc(lat + 5);
		cmp_out(pp);
		rd(8'h1C);
		cmp_reg({28'h0, r[3:0]}, 32'h2);
		cyc(10);
		cmp_out(pg);
		cmp_reg({31'h0, scan_run}, 32'h0);
		cyc(20);
		cmp_out(pp);
		cyc(12);
		cmp_out(ip);
		cmp_reg({31'h0, scan_run}, {31'h0, sc});
	endtask : seq
	task automatic test_done;
		if (miscompares == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	initial begin
		#60000;
		miscompares++;
		test_done();
	end
	initial begin
		void'($urandom(34));
		{pp, pg, ip} = 24'($urandom);
		s = 2'($urandom_range(3, 1));
		cyc(16);
		resetn_in <= 1'b1;
		rd(8'h04); cmp_reg(r, 32'h0);
		rd(8'h08); cmp_reg(r, 32'hE0);
		rd(8'h0C); cmp_reg(r, 32'h1);
		rd(8'h10); cmp_reg(r, 32'hA);
		rd(8'h20); cmp_reg(r, 32'h0);
		cmp_out(8'h0);
		wr(8'h0C, 32'h7); rd(8'h0C); cmp_reg(r, 32'h5);
		wr(8'h10, 32'hFFF); rd(8'h10); cmp_reg(r, 32'hE10);
		wr(8'h14, {30'h0, s});
		sel <= s;
		wr(8'h04, {24'h0, pp});
		wr(8'h08, {24'h0, pg});
		wr(8'h18, {24'h0, ip});
		wr(8'h0C, 32'h1);
		wr(8'h10, 32'h2);
		noise <= 1'b1;
		cyc(8);
		cmp_out(ip);
		wr(8'h00, 32'h1); seq(0, 1'b0);
		wr(8'h00, 32'h1);
		cyc(15);
		trig <= 1'b1;
		cyc(4);
		trig <= 1'b0;
		cyc(30);
		cmp_out(ip);
		wr(8'h0C, 32'h0); wr(8'h00, 32'h1);
		cyc(4);
		cmp_out(pg);
		cyc(25);
		cmp_out(ip);
		wr(8'h0C, 32'h1); wr(8'h10, 32'h0); wr(8'h00, 32'h1);
		cyc(60);
		cmp_out(pg);
		wr(8'h00, 32'h2);
		cyc(4);
		cmp_out(pp);
		cyc(15);
		cmp_out(ip);
		wr(8'h10, 32'h2);
		trig <= 1'b1; seq(3, 1'b0);
		trig <= 1'b0;
		wr(8'h00, 32'h4);
		cyc(2);
		cmp_reg({31'h0, scan_run}, 32'h1);
		wr(8'h00, 32'h1);
		cyc(3);
		cmp_out(ip);
		trig <= 1'b1; seq(3, 1'b1);
		cyc(30);
		cmp_out(ip);
		cmp_reg({31'h0, scan_run}, 32'h1);
		trig <= 1'b0;
		wr(8'h00, 32'h8);
		cyc(2);
		cmp_reg({31'h0, scan_run}, 32'h0);
		test_done();
	end
endmodule : psq_top_tb_top
